// ===== dv/sfp_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// Host controller on the flash pins, clock idles low
module sfp_host_model
(
    input  wire logic       mclk,
    input  wire logic [3:0] pins,
    output logic            cs_n,
    output logic            sck,
    output logic [3:0]      hout,
    output logic [3:0]      hoe
);
    initial {cs_n, sck, hout, hoe} = 10'h200;
    task automatic hold(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // Select or deselect with the lanes released, then let the pin settle
    task automatic frame(input logic lvl);
        {cs_n, hoe} <= {lvl, 4'h0};
        hold(8);
    endtask
    // Data moves at the fall, answers are read late in the high phase
    task automatic shift(input logic [7:0] b, input int w, input logic tx,
                         output logic [7:0] got);
        logic [15:0] acc;
        acc = '0;
        hoe <= tx ? 4'h0 : 4'hf >> (4 - w);
        for (int k = 0; k < 8 / w + tx; k++)
        begin
            hout <= 4'(b >> (8 - w));
            b = b << w;
            hold(4);
            sck <= 1'b1;
            hold(4);
            acc = (acc << w) | 16'(w == 1 ? 4'(pins[1])
                                          : pins & ~(4'hf << w));
            sck <= 1'b0;
        end
        got = acc[7:0];
    endtask
endmodule
`default_nettype wire

// ===== dv/sfp_pin_front_tb.sv
`timescale 1ns/10ps
`default_nettype none
module sfp_pin_front_tb import sfp_pkg::*;;
    logic mclk = 0, resetn = 0, tgl = 0, op_busy = 0, dir_tx = 0, tx_valid = 0;
    logic quad_io_enable = 0, status_protect_hi = 0, status_protect_lo = 1;
    logic rx_ready = 0, cs_n_pin, sck_pin, tx_ready, rx_valid, rx_overrun;
    logic armed, sel_active, standby, status_write_blocked;
    logic [1:0] lane_mode = 0;
    logic [7:0] tx_data = 0, rx_data, got, block_idx;
    logic [23:0] addr_in = 0;
    logic [3:0] io_in, io_out, io_oe, hout, hoe;
    logic [11:0] sector_idx;
    logic [8:0] half_idx;
    int n_mismatch = 0, check_count = 0, n_txr = 0;
    sfp_pin_front u_sfp_pin_front (.mclk, .resetn, .cs_n_pin, .sck_pin,
        .io_in, .io_out, .io_oe, .quad_io_enable, .status_protect_hi,
        .status_protect_lo, .op_busy, .lane_mode, .dir_tx, .tx_data,
        .tx_valid, .tx_ready, .rx_data, .rx_valid, .rx_ready, .rx_overrun,
        .armed, .sel_active, .standby, .status_write_blocked, .addr_in,
        .sector_idx, .half_idx, .block_idx);
    sfp_host_model u_sfp_host_model (.mclk, .pins(io_in), .cs_n(cs_n_pin),
        .sck(sck_pin), .hout, .hoe);
    always #5 mclk = ~mclk;
    always @(posedge mclk) tgl <= ~tgl;
    // Count byte-taken pulses of the transmit side
    always @(posedge mclk) if (tx_ready) n_txr <= n_txr + 1;
    // Wire levels: pull-ups on lanes 2 and 3, a moving pattern elsewhere
    always_comb
        for (int i = 0; i < 4; i++)
            io_in[i] = io_oe[i] ? io_out[i] : hoe[i] ? hout[i]
                     : (i > 1) | tgl;
    task automatic hold(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic t_start();
        chk(standby, 1'b1);
        u_sfp_host_model.shift(8'h81, 1, 1'b0, got);
        hold(8);
        chk({armed, rx_valid, io_oe}, 6'h0);
        u_sfp_host_model.frame(1'b0);
        chk({armed, sel_active, standby}, 3'h6);
        op_busy <= 1'b1;
        u_sfp_host_model.frame(1'b1);
        chk(standby, 1'b0);
        op_busy <= 1'b0;
        hold(2);
        chk(standby, 1'b1);
    endtask
    task automatic t_rx(input int w, input logic [1:0] m, input logic [7:0] b);
        {lane_mode, quad_io_enable} <= {m, m[1]};
        u_sfp_host_model.frame(1'b0);
        u_sfp_host_model.shift(b, w, 1'b0, got);
        u_sfp_host_model.frame(1'b1);
        chk({rx_valid, rx_data}, {1'b1, b});
        rx_ready <= 1'b1;
        hold(1);
        rx_ready <= 1'b0;
        hold(2);
    endtask
    task automatic t_tx(input int w, input logic [1:0] m, input logic [7:0] b);
        int c0 = n_txr;
        {lane_mode, quad_io_enable, dir_tx, tx_valid, tx_data} <= {m, m[1], 2'h3, b};
        u_sfp_host_model.frame(1'b0);
        u_sfp_host_model.shift(8'h00, w, 1'b1, got);
        {dir_tx, tx_valid} <= 2'h0;
        u_sfp_host_model.frame(1'b1);
        chk({got, io_oe}, {b, 4'h0});
        chk(n_txr - c0, 1);
    endtask
    // Fill the FIFO: eighteen bytes fit, the nineteenth is lost and flagged
    task automatic t_over();
        {lane_mode, quad_io_enable} <= 3'h5;
        u_sfp_host_model.frame(1'b0);
        repeat (18) u_sfp_host_model.shift(8'h5a, 4, 1'b0, got);
        hold(4);
        chk({rx_overrun, rx_valid, rx_data}, {2'h1, 8'h5a});
        u_sfp_host_model.shift(8'h0f, 4, 1'b0, got);
        hold(4);
        chk(rx_overrun, 1'b1);
        u_sfp_host_model.frame(1'b1);
        chk(rx_overrun, 1'b0);
        rx_ready <= 1'b1;
        hold(24);
        chk(rx_valid, 1'b0);
        rx_ready <= 1'b0;
    endtask
    // Pause in mid byte: clock pulses while paused must not shift
    task automatic t_pause();
        {lane_mode, quad_io_enable} <= 3'h0;
        u_sfp_host_model.frame(1'b0);
        u_sfp_host_model.shift(8'h44, 2, 1'b0, got);
        {u_sfp_host_model.hoe, u_sfp_host_model.hout} <= 8'h80;
        hold(8);
        repeat (4)
        begin
            u_sfp_host_model.sck <= ~u_sfp_host_model.sck;
            hold(8);
        end
        u_sfp_host_model.hoe <= 4'h0;
        hold(8);
        u_sfp_host_model.shift(8'h44, 2, 1'b0, got);
        u_sfp_host_model.frame(1'b1);
        chk({rx_valid, rx_data}, 9'h1aa);
        rx_ready <= 1'b1;
        hold(1);
        rx_ready <= 1'b0;
    endtask
    task automatic t_misc();
        logic [23:0] tab [3] = '{24'h018000, 24'hfe7fff, 24'hffffff};
        {quad_io_enable, u_sfp_host_model.hoe} <= 5'h04;
        u_sfp_host_model.hout <= 4'h0;
        hold(8);
        chk(status_write_blocked, 1'b1);
        quad_io_enable <= 1'b1;
        hold(8);
        chk(status_write_blocked, 1'b0);
        quad_io_enable <= 1'b0;
        status_protect_lo <= 1'b0;
        hold(2);
        chk(status_write_blocked, 1'b0);
        status_protect_hi <= 1'b1;
        status_protect_lo <= 1'b1;
        hold(2);
        chk(status_write_blocked, 1'b0);
        foreach (tab[i])
        begin
            addr_in <= tab[i];
            hold(2);
            chk({sector_idx, half_idx, block_idx}, {12'(tab[i] / 4096),
                 9'(tab[i] / 32768), 8'(tab[i] / 65536)});
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        hold(5);
        resetn <= 1'b1;
        hold(8);
        t_start();
        t_rx(1, 2'b00, 8'ha5);
        t_rx(2, 2'b01, 8'h3c);
        t_rx(4, 2'b10, 8'h96);
        t_over();
        t_pause();
        t_tx(1, 2'b00, 8'hc3);
        t_tx(2, 2'b01, 8'h69);
        t_tx(4, 2'b10, 8'h5a);
        t_misc();
        summarize();
    end
    initial
    begin
        hold(20000);
        n_mismatch++;
        summarize();
    end
endmodule
`default_nettype wire

// ===== src/sfp_fifo.sv
`timescale 1ns/10ps
`default_nettype none
// Receive FIFO with registered read side
module sfp_fifo
    import sfp_pkg::*;
#(
    parameter int WIDTH = BYTE_W,
    parameter int DEPTH = FIFO_DEPTH_DEF
)
(
    input wire logic    mclk,
    input wire logic    resetn,
    sfp_stream_if.snk   wr,
    sfp_stream_if.src   rd
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

    // =====================================================================
    // Elaboration check
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
    begin : g_bad_param
        $error("sfp_fifo: DEPTH must be a power of two >= 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_reg, wr_ptr_next;
    logic [AW-1:0]    rd_ptr_reg, rd_ptr_next;
    logic [AW:0]      count_reg, count_next;
    logic             out_valid_reg, out_valid_next;
    logic [WIDTH-1:0] out_data_reg, out_data_next;
    logic             push;
    logic             load;

    // =====================================================================
    // Pointer, count and output stage
    always_comb
    begin
        wr.ready       = (count_reg != FULL_CNT);
        push           = wr.valid && (count_reg != FULL_CNT);
        load           = (count_reg != '0) && (!out_valid_reg || rd.ready);
        wr_ptr_next    = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
        rd_ptr_next    = load ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
        count_next     = count_reg + {{AW{1'b0}}, push}
                                   - {{AW{1'b0}}, load};
        out_valid_next = out_valid_reg && !rd.ready;
        out_data_next  = out_data_reg;
        if (load)
        begin
            out_valid_next = 1'b1;
            out_data_next  = mem[rd_ptr_reg];
        end
    end

    assign rd.valid = out_valid_reg;
    assign rd.data  = out_data_reg;

    // Registers
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            wr_ptr_reg    <= '0;
            rd_ptr_reg    <= '0;
            count_reg     <= '0;
            out_valid_reg <= 1'b0;
            out_data_reg  <= '0;
        end
        else
        begin
            wr_ptr_reg    <= wr_ptr_next;
            rd_ptr_reg    <= rd_ptr_next;
            count_reg     <= count_next;
            out_valid_reg <= out_valid_next;
            out_data_reg  <= out_data_next;
        end
    end

    // Storage array
    always_ff @(posedge mclk)
    begin
        if (push)
        begin
            mem[wr_ptr_reg] <= wr.data;
        end
    end

endmodule
`default_nettype wire

// ===== src/sfp_pin_front.sv
`timescale 1ns/10ps
`default_nettype none
// Serial flash pin front end, device side
module sfp_pin_front
    import sfp_pkg::*;
#(
    parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
)
(
    input  wire logic                mclk,
    input  wire logic                resetn,
    input  wire logic                cs_n_pin,
    input  wire logic                sck_pin,
    input  wire logic [3:0]          io_in,
    output logic      [3:0]          io_out,
    output logic      [3:0]          io_oe,
    input  wire logic                quad_io_enable,
    input  wire logic                status_protect_hi,
    input  wire logic                status_protect_lo,
    input  wire logic                op_busy,
    input  wire logic [1:0]          lane_mode,
    input  wire logic                dir_tx,
    input  wire logic [BYTE_W-1:0]   tx_data,
    input  wire logic                tx_valid,
    output logic                     tx_ready,
    output logic [BYTE_W-1:0]        rx_data,
    output logic                     rx_valid,
    input  wire logic                rx_ready,
    output logic                     rx_overrun,
    output logic                     armed,
    output logic                     sel_active,
    output logic                     standby,
    output logic                     status_write_blocked,
    input  wire logic [ADDR_W-1:0]   addr_in,
    output logic [SECTOR_W-1:0]      sector_idx,
    output logic [HALF_W-1:0]        half_idx,
    output logic [BLOCK_W-1:0]       block_idx
);

    // =====================================================================
    // Elaboration check
    if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0)
    begin : g_bad_param
        $error("sfp_pin_front: FIFO_DEPTH must be a power of two >= 2");
    end

    // =====================================================================
    // Pin synchronisers: three stages, accepted when stages two and three agree
    logic [PIN_W-1:0] pin_s1_reg, pin_s2_reg, pin_s3_reg;
    logic [PIN_W-1:0] pin_f_reg, pin_f_next;
    logic [PIN_W-1:0] pin_d_reg;

    // Filter next value
    always_comb
    begin
        pin_f_next = pin_f_reg;
        for (int i = 0; i < PIN_W; i++)
        begin
            if (pin_s2_reg[i] == pin_s3_reg[i])
            begin
                pin_f_next[i] = pin_s3_reg[i];
            end
        end
    end

    // Synchroniser and filter registers
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            pin_s1_reg <= PIN_F_RST;
            pin_s2_reg <= PIN_F_RST;
            pin_s3_reg <= PIN_F_RST;
            pin_f_reg  <= PIN_F_RST;
            pin_d_reg  <= PIN_F_RST;
        end
        else
        begin
            pin_s1_reg <= {cs_n_pin, sck_pin, io_in};
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
            pin_f_reg  <= pin_f_next;
            pin_d_reg  <= pin_f_reg;
        end
    end

    // =====================================================================
    // Edge detection on the filtered pins
    logic       cs_f, sck_f;
    logic [3:0] io_f;
    logic       cs_fall, sck_rise, sck_fall;

    assign cs_f     = pin_f_reg[PIN_CS];
    assign sck_f    = pin_f_reg[PIN_SCK];
    assign io_f     = pin_f_reg[3:0];
    assign cs_fall  = pin_d_reg[PIN_CS] && !cs_f;
    assign sck_rise = !pin_d_reg[PIN_SCK] && sck_f;
    assign sck_fall = pin_d_reg[PIN_SCK] && !sck_f;

    // =====================================================================
    // Link state, shifters and status
    sfp_stream_if #(.W(BYTE_W)) rx_wr ();
    sfp_stream_if #(.W(BYTE_W)) rx_rd ();

    sfp_link_e         link_reg, link_next;
    logic              armed_reg, armed_next;
    logic [3:0]        width;
    logic [7:0]        rx_sh_reg, rx_sh_next;
    logic [3:0]        rx_cnt_reg, rx_cnt_next;
    logic              pend_reg, pend_next;
    logic [7:0]        pend_byte_reg, pend_byte_next;
    logic              overrun_reg, overrun_next;
    logic [7:0]        tx_sh_reg, tx_sh_next;
    logic [3:0]        tx_cnt_reg, tx_cnt_next;
    logic              tx_on_reg, tx_on_next;
    logic              tx_ready_reg, tx_ready_next;
    logic [3:0]        io_out_reg, io_out_next;
    logic [3:0]        io_oe_reg, io_oe_next;
    logic              sel_reg, sel_next;
    logic              standby_reg, standby_next;
    logic              wp_blk_reg, wp_blk_next;
    logic [3:0]        rx_sum;
    logic [7:0]        byte_in;
    logic [7:0]        tx_src;

    assign width = lane_width(lane_mode, quad_io_enable);
    assign rx_sum = rx_cnt_reg + width;

    always_comb
    begin
        link_next      = link_reg;
        armed_next     = armed_reg || cs_fall;
        rx_sh_next     = rx_sh_reg;
        rx_cnt_next    = rx_cnt_reg;
        pend_next      = pend_reg && !rx_wr.ready;
        pend_byte_next = pend_byte_reg;
        overrun_next   = overrun_reg;
        tx_sh_next     = tx_sh_reg;
        tx_cnt_next    = tx_cnt_reg;
        tx_on_next     = tx_on_reg;
        tx_ready_next  = 1'b0;
        io_out_next    = io_out_reg;
        byte_in        = rx_sh_reg;
        tx_src         = tx_sh_reg;

        // Select, deselect and pause sequencing
        unique case (link_reg)
            LK_DESEL:
            begin
                if (!cs_f && (armed_reg || cs_fall))
                begin
                    link_next = LK_ACTIVE;
                end
            end
            LK_ACTIVE:
            begin
                if (cs_f)
                begin
                    link_next = LK_DESEL;
                end
                else if (!quad_io_enable && !io_f[LANE_PAUSE] && !sck_f)
                begin
                    link_next = LK_PAUSE;
                end
            end
            LK_PAUSE:
            begin
                if (cs_f)
                begin
                    link_next = LK_DESEL;
                end
                else if ((io_f[LANE_PAUSE] || quad_io_enable) && !sck_f)
                begin
                    link_next = LK_ACTIVE;
                end
            end
            default:
            begin
                link_next = LK_DESEL;
            end
        endcase

        // Receive on rising clock edges
        if (link_reg == LK_ACTIVE && !cs_f && !dir_tx && sck_rise)
        begin
            unique case (width)
                4'h2:    byte_in = {rx_sh_reg[5:0], io_f[1:0]};
                4'h4:    byte_in = {rx_sh_reg[3:0], io_f};
                default: byte_in = {rx_sh_reg[6:0], io_f[0]};
            endcase
            rx_sh_next  = byte_in;
            rx_cnt_next = rx_sum;
            if (rx_sum >= BITS_PER_BYTE)
            begin
                rx_cnt_next = '0;
                if (pend_next)
                begin
                    overrun_next = 1'b1;
                end
                else
                begin
                    pend_next      = 1'b1;
                    pend_byte_next = byte_in;
                end
            end
        end

        // Transmit after falling clock edges
        if (link_reg == LK_ACTIVE && !cs_f && dir_tx && sck_fall)
        begin
            tx_on_next = 1'b1;
            if (tx_cnt_reg == '0)
            begin
                tx_src        = tx_valid ? tx_data : TX_IDLE_BYTE;
                tx_ready_next = tx_valid;
            end
            unique case (width)
                4'h2:    io_out_next = {2'b00, tx_src[7:6]};
                4'h4:    io_out_next = tx_src[7:4];
                default: io_out_next = {2'b00, tx_src[7], 1'b0};
            endcase
            tx_sh_next  = tx_src << width;
            tx_cnt_next = (tx_cnt_reg + width) & 4'h7;
        end

        // Deselect ends the sequence and drops partial bytes
        if (link_next == LK_DESEL)
        begin
            rx_cnt_next  = '0;
            tx_cnt_next  = '0;
            tx_on_next   = 1'b0;
            overrun_next = 1'b0;
        end
        if (!dir_tx)
        begin
            tx_on_next  = 1'b0;
            tx_cnt_next = '0;
        end

        // Drivers only while actively transmitting, released in pause
        io_oe_next = (link_next == LK_ACTIVE && tx_on_next)
                   ? lane_mask(width) : OE_NONE;

        sel_next     = (link_next != LK_DESEL);
        standby_next = cs_f && !op_busy;
        wp_blk_next  = !quad_io_enable && !status_protect_hi
                     && status_protect_lo && !io_f[LANE_WP];
    end

    assign rx_wr.valid = pend_reg;
    assign rx_wr.data  = pend_byte_reg;
    assign rx_rd.ready = rx_ready;
    assign rx_valid    = rx_rd.valid;
    assign rx_data     = rx_rd.data;

    // Registers
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            link_reg      <= LK_DESEL;
            armed_reg     <= 1'b0;
            rx_sh_reg     <= '0;
            rx_cnt_reg    <= '0;
            pend_reg      <= 1'b0;
            pend_byte_reg <= '0;
            overrun_reg   <= 1'b0;
            tx_sh_reg     <= '0;
            tx_cnt_reg    <= '0;
            tx_on_reg     <= 1'b0;
            tx_ready_reg  <= 1'b0;
            io_out_reg    <= OE_NONE;
            io_oe_reg     <= OE_NONE;
            sel_reg       <= 1'b0;
            standby_reg   <= 1'b0;
            wp_blk_reg    <= 1'b0;
        end
        else
        begin
            link_reg      <= link_next;
            armed_reg     <= armed_next;
            rx_sh_reg     <= rx_sh_next;
            rx_cnt_reg    <= rx_cnt_next;
            pend_reg      <= pend_next;
            pend_byte_reg <= pend_byte_next;
            overrun_reg   <= overrun_next;
            tx_sh_reg     <= tx_sh_next;
            tx_cnt_reg    <= tx_cnt_next;
            tx_on_reg     <= tx_on_next;
            tx_ready_reg  <= tx_ready_next;
            io_out_reg    <= io_out_next;
            io_oe_reg     <= io_oe_next;
            sel_reg       <= sel_next;
            standby_reg   <= standby_next;
            wp_blk_reg    <= wp_blk_next;
        end
    end

    // =====================================================================
    // Address map
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            sector_idx <= '0;
            half_idx   <= '0;
            block_idx  <= '0;
        end
        else
        begin
            sector_idx <= addr_in[ADDR_W-1:SECTOR_LSB];
            half_idx   <= addr_in[ADDR_W-1:HALF_LSB];
            block_idx  <= addr_in[ADDR_W-1:BLOCK_LSB];
        end
    end

    // =====================================================================
    // Receive FIFO
    sfp_fifo #(
        .WIDTH (BYTE_W),
        .DEPTH (FIFO_DEPTH)
    ) u_rx_fifo (
        .mclk   (mclk),
        .resetn (resetn),
        .wr     (rx_wr.snk),
        .rd     (rx_rd.src)
    );

    assign io_out               = io_out_reg;
    assign io_oe                = io_oe_reg;
    assign tx_ready             = tx_ready_reg;
    assign rx_overrun           = overrun_reg;
    assign armed                = armed_reg;
    assign sel_active           = sel_reg;
    assign standby              = standby_reg;
    assign status_write_blocked = wp_blk_reg;

    // =====================================================================
    // Assertions
    a_desel_hiz: assert property (@(posedge mclk) disable iff (!resetn)
        cs_f |=> io_oe_reg == OE_NONE)
        else $error("drivers enabled while deselected");
    a_standby_lvl: assert property (@(posedge mclk) disable iff (!resetn)
        (cs_f && !op_busy) [*2] |-> standby_reg)
        else $error("standby not shown while idle and deselected");
    a_select_act: assert property (@(posedge mclk) disable iff (!resetn)
        (link_reg == LK_ACTIVE && !cs_f) |=> sel_reg)
        else $error("selected device not active");
    a_arm_first: assert property (@(posedge mclk) disable iff (!resetn)
        !armed_reg |-> link_reg == LK_DESEL)
        else $error("selection before first select edge");
    a_rx_rise_only: assert property (@(posedge mclk) disable iff (!resetn)
        (!sck_rise && !cs_f && link_reg == LK_ACTIVE)
        |=> $stable(rx_sh_reg))
        else $error("receive shift without rising clock");
    a_tx_fall_only: assert property (@(posedge mclk) disable iff (!resetn)
        $changed(io_out_reg) |-> $past(sck_fall))
        else $error("output changed without falling clock");
    a_single_lane: assert property (@(posedge mclk) disable iff (!resetn)
        ($past(width) == 4'h1 && io_oe_reg != OE_NONE)
        |-> io_oe_reg == OE_SINGLE)
        else $error("single mode drives wrong lane");
    a_quad_gate: assert property (@(posedge mclk) disable iff (!resetn)
        io_oe_reg[LANE_PAUSE] |-> $past(quad_io_enable))
        else $error("lane three driven without quad enable");
    a_wp_block: assert property (@(posedge mclk) disable iff (!resetn)
        (!quad_io_enable && !status_protect_hi && status_protect_lo
         && !io_f[LANE_WP]) |=> wp_blk_reg)
        else $error("write protect not honoured");
    a_pause_hiz: assert property (@(posedge mclk) disable iff (!resetn)
        link_reg == LK_PAUSE |-> io_oe_reg == OE_NONE)
        else $error("drivers enabled during pause");
    a_pause_entry: assert property (@(posedge mclk) disable iff (!resetn)
        $rose(link_reg == LK_PAUSE)
        |-> $past(!sck_f && !io_f[LANE_PAUSE]))
        else $error("pause entered with clock high");
    a_sector_map: assert property (@(posedge mclk) disable iff (!resetn)
        ##1 sector_idx == $past(addr_in[23:12])
        && block_idx == $past(addr_in[23:16]))
        else $error("address map mismatch");

endmodule
`default_nettype wire

// ===== src/sfp_pkg.sv
// Behaviour
// - Chip select high deselects: inputs ignored, all pin drivers released.
// - Deselected device shows standby unless an internal write operation runs.
// - Chip select low selects the device and enters active power mode.
// - No command is accepted before the first chip-select falling edge after reset.
// - Command, address and write data are captured on rising serial-clock edges.
// - Output data changes only after falling serial-clock edges.
// - Single-bit commands receive on lane zero and transmit on lane one.
// - Dual commands use lanes zero and one, quad commands all four lanes, in both directions.
// - Quad off, protect bits 0/1 and write-protect low block status writes.
// - With quad enabled the write-protect pin serves as data lane two.
// - Fourth pin pauses with quad off, serves as data lane three otherwise.
// - Pause suspends transfer without resetting the bit sequence, only while selected.
// - Pause starts on pause low with clock low, ends on pause high with clock low.
// - Write-protect and pause inputs idle high when the host leaves them open.
// - 24-bit address maps to 4096 sectors, 512 half blocks and 256 blocks.
package sfp_pkg;

    // =====================================================================
    // Data path sizes
    localparam int         BYTE_W         = 8;
    localparam int         FIFO_DEPTH_DEF = 16;
    localparam int         PIN_W          = 6;
    localparam logic [3:0] BITS_PER_BYTE  = 4'h8;
    localparam logic [7:0] TX_IDLE_BYTE   = 8'hff;

    // =====================================================================
    // Pin vector layout {cs, sck, lane3..lane0} and reset values
    localparam int         PIN_CS         = 5;
    localparam int         PIN_SCK        = 4;
    localparam int         LANE_WP        = 2;
    localparam int         LANE_PAUSE     = 3;
    localparam logic [5:0] PIN_F_RST      = 6'h0f;
    localparam logic [3:0] OE_NONE        = 4'h0;
    localparam logic [3:0] OE_SINGLE      = 4'h2;
    localparam logic [3:0] OE_DUAL        = 4'h3;
    localparam logic [3:0] OE_QUAD        = 4'hf;

    // =====================================================================
    // Address map fields
    localparam int          ADDR_W        = 24;
    localparam logic [23:0] ADDR_LAST     = 24'hffffff;
    localparam int          SECTOR_LSB    = 12;
    localparam int          SECTOR_W      = 12;
    localparam int          HALF_LSB      = 15;
    localparam int          HALF_W        = 9;
    localparam int          BLOCK_LSB     = 16;
    localparam int          BLOCK_W       = 8;

    // =====================================================================
    // Modes and states
    typedef enum logic [1:0]
    {
        LANE_SINGLE = 2'b00,
        LANE_DUAL   = 2'b01,
        LANE_QUAD   = 2'b10
    } sfp_lane_e;

    typedef enum logic [1:0]
    {
        LK_DESEL  = 2'b00,
        LK_ACTIVE = 2'b01,
        LK_PAUSE  = 2'b10
    } sfp_link_e;

    // Bits moved per clock edge; quad falls back to single without enable
    function automatic logic [3:0] lane_width(input logic [1:0] mode,
                                              input logic       qe);
        lane_width = 4'h1;
        if (mode == LANE_DUAL)
        begin
            lane_width = 4'h2;
        end
        else if (mode == LANE_QUAD && qe)
        begin
            lane_width = 4'h4;
        end
    endfunction

    // Lanes driven while transmitting
    function automatic logic [3:0] lane_mask(input logic [3:0] width);
        lane_mask = OE_SINGLE;
        if (width == 4'h2)
        begin
            lane_mask = OE_DUAL;
        end
        else if (width == 4'h4)
        begin
            lane_mask = OE_QUAD;
        end
    endfunction

endpackage

// ===== src/sfp_stream_if.sv
`timescale 1ns/10ps
`default_nettype none
// Valid/ready byte stream between the pin front end and its FIFO
interface sfp_stream_if #(parameter int W = 8);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire
